// >>> pkg/ioppc_pkg.sv
// constants for the io port pad control block
// Functional notes
// - peripheral selection overrides port use
// - open-drain output drives low on latch 0
// - open-drain direction 0 means input only
// - cmos direction 1 drives latch, 0 input
// - pull-up on cmos pins only, when enable and latch 1
// - pull-up ignores peripheral selection
// - stop entry clears selections, pins float
// - misc register write-only, bits 3 and 2
// - misc register zero on reset and stop
// - peripheral outputs push-pull, serial out selectable
// - latches reached only by port instructions
// - r ports nibble access, d port bits
// - each selection register owns its pins
// - drain select 1 gives open-drain serial out
// - all pin latches set after reset
// - direction bits reset to zero
package ioppc_pkg;
  // register addresses on the nibble-wide register port
  localparam logic [9:0] ADDR_PORT_MODE_REG_A = 10'h004;
  localparam logic [9:0] ADDR_SMR = 10'h005;
  localparam logic [9:0] ADDR_MISC = 10'h00c;
  localparam logic [9:0] ADDR_AMR = 10'h019;
  localparam logic [9:0] ADDR_PORT_MODE_REG_B = 10'h024;
  localparam logic [9:0] ADDR_DCD0 = 10'h02c;
  localparam logic [9:0] ADDR_DCD1 = 10'h02d;
  localparam logic [9:0] ADDR_DCR0 = 10'h030;
  // field positions
  localparam int MISC_PULLUP_BIT = 3;
  localparam int MISC_DRAIN_BIT = 2;
  localparam int PORT_MODE_REG_A_SO_BIT = 0;
  localparam int PORT_MODE_REG_A_SI_BIT = 1;
  localparam int PORT_MODE_REG_A_TOC_BIT = 2;
  localparam int SMR_SCK_BIT = 3;
  localparam int PORT_MODE_REG_B_IRQ0_BIT = 0;
  localparam int PORT_MODE_REG_B_STOP_CLEAR_PIN_BIT = 3;
  // reset values
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [1:0] MISC_RESET = 2'h0;
  localparam logic [21:0] LATCH_RESET = 22'h3fffff;
  localparam logic [21:0] DIR_RESET = 22'h000000;
  // pin slots: d0..d5 at 0..5, rN bit b at 6 + 4*N + b
  localparam int NUM_SLOTS = 22;
  localparam int NUM_D = 6;
  localparam int R_BASE = 6;
  localparam logic [21:0] PIN_PRESENT = 22'h3bffff;
  localparam logic [21:0] PIN_CMOS = 22'h3803ff;
  localparam int PIN_IRQ0 = 0;
  localparam int PIN_STOP_CLEAR_PIN = 4;
  localparam int PIN_SCK = 6;
  localparam int PIN_SI = 7;
  localparam int PIN_SO = 8;
  localparam int PIN_TOC = 9;
  localparam int PIN_AN_BASE = 18;
endpackage : ioppc_pkg

// >>> verilog/ioppc_pad_cell.sv
// one pad's driver, enable and pull-up decision
`timescale 1ns/1ps
`default_nettype none
module ioppc_pad_cell (
  // pad type and state
  input wire logic is_cmos,
  input wire logic halt,
  input wire logic dir,
  input wire logic latch,
  input wire logic drain_sel,
  input wire logic pullup_en,
  // peripheral side
  input wire logic periph_sel,
  input wire logic periph_oe,
  input wire logic periph_data,
  // pad control
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pu
);
  // driver choice, halt first, then peripheral, then port
  always_comb begin
    pad_out = 1'b0;
    pad_oe = 1'b0;
    if (halt) begin
      pad_oe = 1'b0;
    end else if (periph_sel) begin
      pad_out = periph_data;
      pad_oe = periph_oe & ~(drain_sel & periph_data);
    end else if (is_cmos) begin
      // drain select also on port use
      pad_out = latch;
      pad_oe = dir & ~(drain_sel & latch);
    end else begin
      pad_out = 1'b0;
      pad_oe = dir & ~latch;
    end
  end

  assign pad_pu = is_cmos & pullup_en & latch & ~halt;
endmodule : ioppc_pad_cell
`default_nettype wire

// >>> verilog/ioppc_top.sv
// pad control for the d and r ports of the controller
`timescale 1ns/1ps
`default_nettype none
module ioppc_top
  import ioppc_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // register write port, nibble data
  input wire logic REG_WR,
  input wire logic [9:0] REG_ADDR,
  input wire logic [3:0] REG_WDATA,
  // d port bit instructions
  input wire logic D_SET,
  input wire logic D_CLR,
  input wire logic D_TEST,
  input wire logic [2:0] D_BIT,
  output logic D_LEVEL,
  // r port nibble instructions
  input wire logic R_WRITE,
  input wire logic R_READ,
  input wire logic [1:0] R_GROUP,
  input wire logic [3:0] R_WDATA,
  output logic [3:0] R_RDATA,
  // stop mode level
  input wire logic STOP_MODE,
  // peripheral outputs toward the pads
  input wire logic PERI_SCK_OUT,
  input wire logic PERI_SCK_OE,
  input wire logic PERI_SO,
  input wire logic PERI_TOC,
  // pad levels and analog selection toward the peripherals
  output logic PERI_SCK_IN,
  output logic PERI_SI,
  output logic PERI_IRQ0_N,
  output logic PERI_STOP_CLEAR_PIN_N,
  output logic [3:1] AN_SELECT,
  // pads
  input wire logic [21:0] PAD_IN,
  output logic [21:0] PAD_OUT,
  output logic [21:0] PAD_OE,
  output logic [21:0] PAD_PULLUP
);
  // write-only control registers
  logic [3:0] port_mode_reg_a_ff, smr_ff, amr_ff, port_mode_reg_b_ff;
  logic [3:0] nxt_port_mode_reg_a, nxt_smr, nxt_amr, nxt_port_mode_reg_b;
  logic [1:0] misc_ff, nxt_misc;
  logic [21:0] latch_ff, nxt_latch;
  logic [21:0] dir_ff, nxt_dir;
  logic stop_seen_ff, nxt_stop_seen;
  // answers to port instructions
  logic d_level_ff, nxt_d_level;
  logic [3:0] r_rdata_ff, nxt_r_rdata;
  // pad and peripheral output flops
  logic [21:0] pad_out_ff, pad_oe_ff, pad_pu_ff;
  logic [21:0] cell_out, cell_oe, cell_pu;
  logic [4:0] peri_in_ff, nxt_peri_in;
  logic [2:0] an_ff;
  // per-slot peripheral routing
  logic [21:0] psel, poe, pdat, drain;
  logic stop_entry;
  logic pullup_enable;
  logic serial_out_drain_select;

  // slot of r group bit
  function automatic int r_slot(input logic [1:0] grp, input int b);
    r_slot = R_BASE + 4 * int'(grp) + b;
  endfunction : r_slot

  assign stop_entry = STOP_MODE & ~stop_seen_ff;
  assign pullup_enable = misc_ff[1];
  assign serial_out_drain_select = misc_ff[0];

  // register writes and port instructions
  always_comb begin
    nxt_port_mode_reg_a = port_mode_reg_a_ff;
    nxt_smr = smr_ff;
    nxt_amr = amr_ff;
    nxt_port_mode_reg_b = port_mode_reg_b_ff;
    nxt_misc = misc_ff;
    nxt_latch = latch_ff;
    nxt_dir = dir_ff;
    nxt_stop_seen = STOP_MODE;
    if (stop_entry) begin
      nxt_port_mode_reg_a = MODE_RESET;
      nxt_smr = MODE_RESET;
      nxt_amr = MODE_RESET;
      nxt_port_mode_reg_b = MODE_RESET;
      nxt_misc = MISC_RESET;
      nxt_latch = LATCH_RESET;
      nxt_dir = DIR_RESET;
    end else begin
      if (REG_WR) begin
        case (REG_ADDR)
          ADDR_PORT_MODE_REG_A: nxt_port_mode_reg_a = REG_WDATA;
          ADDR_SMR: nxt_smr = REG_WDATA;
          ADDR_AMR: nxt_amr = REG_WDATA;
          ADDR_PORT_MODE_REG_B: nxt_port_mode_reg_b = REG_WDATA;
          // only bits 3 and 2 kept
          ADDR_MISC: nxt_misc = {REG_WDATA[MISC_PULLUP_BIT], REG_WDATA[MISC_DRAIN_BIT]};
          ADDR_DCD0: nxt_dir[3:0] = REG_WDATA;
          ADDR_DCD1: nxt_dir[5:4] = REG_WDATA[1:0];
          ADDR_DCR0: nxt_dir[9:6] = REG_WDATA;
          ADDR_DCR0 + 10'h001: nxt_dir[13:10] = REG_WDATA;
          ADDR_DCR0 + 10'h002: nxt_dir[17:14] = REG_WDATA;
          ADDR_DCR0 + 10'h003: nxt_dir[21:18] = REG_WDATA & 4'he;
          default: nxt_port_mode_reg_a = port_mode_reg_a_ff;
        endcase
      end
      if (D_SET && (D_BIT < 3'h6)) begin
        nxt_latch[D_BIT] = 1'b1;
      end else if (D_CLR && (D_BIT < 3'h6)) begin
        nxt_latch[D_BIT] = 1'b0;
      end
      if (R_WRITE) begin
        for (int b = 0; b < 4; b++) begin
          if (PIN_PRESENT[r_slot(R_GROUP, b)]) begin
            nxt_latch[r_slot(R_GROUP, b)] = R_WDATA[b];
          end
        end
      end
    end
  end

  // control registers
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      port_mode_reg_a_ff <= MODE_RESET;
      smr_ff <= MODE_RESET;
      amr_ff <= MODE_RESET;
      port_mode_reg_b_ff <= MODE_RESET;
      misc_ff <= MISC_RESET;
      latch_ff <= LATCH_RESET;
      dir_ff <= DIR_RESET;
      stop_seen_ff <= 1'b0;
    end else begin
      port_mode_reg_a_ff <= nxt_port_mode_reg_a;
      smr_ff <= nxt_smr;
      amr_ff <= nxt_amr;
      port_mode_reg_b_ff <= nxt_port_mode_reg_b;
      misc_ff <= nxt_misc;
      latch_ff <= nxt_latch;
      dir_ff <= nxt_dir;
      stop_seen_ff <= nxt_stop_seen;
    end
  end

  // peripheral routing per slot
  always_comb begin
    psel = '0;
    poe = '0;
    pdat = '0;
    drain = '0;
    psel[PIN_IRQ0] = port_mode_reg_b_ff[PORT_MODE_REG_B_IRQ0_BIT];
    psel[PIN_STOP_CLEAR_PIN] = port_mode_reg_b_ff[PORT_MODE_REG_B_STOP_CLEAR_PIN_BIT];
    psel[PIN_SCK] = smr_ff[SMR_SCK_BIT];
    poe[PIN_SCK] = PERI_SCK_OE;
    pdat[PIN_SCK] = PERI_SCK_OUT;
    // port_mode_reg_a owns serial in, serial out and timer pins
    psel[PIN_SI] = port_mode_reg_a_ff[PORT_MODE_REG_A_SI_BIT];
    psel[PIN_SO] = port_mode_reg_a_ff[PORT_MODE_REG_A_SO_BIT];
    poe[PIN_SO] = 1'b1;
    pdat[PIN_SO] = PERI_SO;
    psel[PIN_TOC] = port_mode_reg_a_ff[PORT_MODE_REG_A_TOC_BIT];
    poe[PIN_TOC] = 1'b1;
    pdat[PIN_TOC] = PERI_TOC;
    psel[PIN_AN_BASE + 3:PIN_AN_BASE + 1] = amr_ff[3:1];
    drain[PIN_SO] = serial_out_drain_select;
  end

  // one pad cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_pad
      ioppc_pad_cell u_cell (
        .is_cmos(PIN_CMOS[gi]),
        .halt(STOP_MODE | ~PIN_PRESENT[gi]),
        .dir(dir_ff[gi]),
        .latch(latch_ff[gi]),
        .drain_sel(drain[gi]),
        .pullup_en(pullup_enable),
        .periph_sel(psel[gi]),
        .periph_oe(poe[gi]),
        .periph_data(pdat[gi]),
        .pad_out(cell_out[gi]),
        .pad_oe(cell_oe[gi]),
        .pad_pu(cell_pu[gi])
      );
    end
  endgenerate

  // instruction answers and peripheral input levels
  always_comb begin
    nxt_d_level = d_level_ff;
    nxt_r_rdata = r_rdata_ff;
    if (D_TEST && (D_BIT < 3'h6)) begin
      nxt_d_level = PAD_IN[D_BIT];
    end
    if (R_READ) begin
      for (int b = 0; b < 4; b++) begin
        nxt_r_rdata[b] = PAD_IN[r_slot(R_GROUP, b)] & PIN_PRESENT[r_slot(R_GROUP, b)];
      end
    end
    // unselected inputs idle high
    nxt_peri_in[0] = PAD_IN[PIN_SCK] | ~psel[PIN_SCK];
    nxt_peri_in[1] = PAD_IN[PIN_SI] | ~psel[PIN_SI];
    nxt_peri_in[2] = PAD_IN[PIN_IRQ0] | ~psel[PIN_IRQ0];
    nxt_peri_in[3] = PAD_IN[PIN_STOP_CLEAR_PIN] | ~psel[PIN_STOP_CLEAR_PIN];
    nxt_peri_in[4] = 1'b0;
  end

  // output flops
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      d_level_ff <= 1'b0;
      r_rdata_ff <= 4'h0;
      pad_out_ff <= '0;
      pad_oe_ff <= '0;
      pad_pu_ff <= '0;
      peri_in_ff <= 5'h0f;
      an_ff <= 3'h0;
    end else begin
      d_level_ff <= nxt_d_level;
      r_rdata_ff <= nxt_r_rdata;
      pad_out_ff <= cell_out;
      pad_oe_ff <= cell_oe;
      pad_pu_ff <= cell_pu;
      peri_in_ff <= nxt_peri_in;
      an_ff <= psel[PIN_AN_BASE + 3:PIN_AN_BASE + 1];
    end
  end

  assign D_LEVEL = d_level_ff;
  assign R_RDATA = r_rdata_ff;
  assign PAD_OUT = pad_out_ff;
  assign PAD_OE = pad_oe_ff;
  assign PAD_PULLUP = pad_pu_ff;
  assign PERI_SCK_IN = peri_in_ff[0];
  assign PERI_SI = peri_in_ff[1];
  assign PERI_IRQ0_N = peri_in_ff[2];
  assign PERI_STOP_CLEAR_PIN_N = peri_in_ff[3];
  assign AN_SELECT = an_ff;
endmodule : ioppc_top
`default_nettype wire

// >>> tb/ioppc_properties.sv
// property checker for the pad control block
`timescale 1ns/1ps
`default_nettype none
module ioppc_properties
  import ioppc_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // requests
  input wire logic REG_WR,
  input wire logic [9:0] REG_ADDR,
  input wire logic [3:0] REG_WDATA,
  input wire logic D_TEST,
  input wire logic [2:0] D_BIT,
  input wire logic R_READ,
  input wire logic [1:0] R_GROUP,
  input wire logic STOP_MODE,
  // results
  input wire logic D_LEVEL,
  input wire logic [3:0] R_RDATA,
  input wire logic [3:1] AN_SELECT,
  input wire logic [21:0] PAD_IN,
  input wire logic [21:0] PAD_OUT,
  input wire logic [21:0] PAD_OE,
  input wire logic [21:0] PAD_PULLUP
);
  logic [21:0] pad_ff;
  logic [2:0] bit_ff;
  logic [1:0] grp_ff;
  logic [3:0] nib;
  // pad levels and selectors from the last edge
  always_ff @(posedge CLK_SYS) begin
    pad_ff <= PAD_IN;
    bit_ff <= D_BIT;
    grp_ff <= R_GROUP;
  end
  // expected nibble, missing slot reads 0
  always_comb begin
    nib = 4'(pad_ff >> (R_BASE + 4 * grp_ff));
    if (grp_ff == 2'h3) nib[0] = 1'b0;
  end
  reset_pads_a: assert property (
    @(posedge CLK_SYS) !NRST |=> PAD_OE == 22'h0 && PAD_PULLUP == 22'h0)
    else $error("pads active after reset");
  stop_float_a: assert property (
    @(posedge CLK_SYS) disable iff (!NRST) STOP_MODE |=> PAD_OE == 22'h0 && PAD_PULLUP == 22'h0)
    else $error("pads active in stop");
  drain_low_a: assert property (
    @(posedge CLK_SYS) disable iff (!NRST) (PAD_OE & PAD_OUT & ~PIN_CMOS) == 22'h0)
    else $error("open drain pad driven high");
  pu_cmos_a: assert property (
    @(posedge CLK_SYS) disable iff (!NRST) (PAD_PULLUP & ~(PIN_CMOS & PIN_PRESENT)) == 22'h0)
    else $error("pull-up on non cmos pad");
  pu_off_a: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    REG_WR && REG_ADDR == ADDR_MISC && !REG_WDATA[3] |-> ##2 PAD_PULLUP == 22'h0)
    else $error("pull-ups stay on");
  dtest_level_a: assert property (
    @(posedge CLK_SYS) disable iff (!NRST) D_TEST && D_BIT < 3'h6 |=> D_LEVEL == pad_ff[bit_ff])
    else $error("d test level wrong");
  rread_data_a: assert property (
    @(posedge CLK_SYS) disable iff (!NRST) R_READ |=> R_RDATA == nib)
    else $error("r read nibble wrong");
  stop_clear_a: assert property (
    @(posedge CLK_SYS) disable iff (!NRST) STOP_MODE [*3] |=> AN_SELECT == 3'h0)
    else $error("analog selection kept in stop");
  // main scenarios reached
  cover property (@(posedge CLK_SYS) D_TEST);
  cover property (@(posedge CLK_SYS) R_READ);
  cover property (@(posedge CLK_SYS) $rose(STOP_MODE));
endmodule : ioppc_properties
bind ioppc_top ioppc_properties ioppc_properties_inst (.*);
`default_nettype wire

// >>> tb/ioppc_pad_model.sv
// pad wire model: block drivers, pull-ups, outside source
`timescale 1ns/1ps
`default_nettype none
module ioppc_pad_model (
  // clock
  input wire logic clk_sys,
  // pad controls from the block
  input wire logic [21:0] pad_out,
  input wire logic [21:0] pad_oe,
  input wire logic [21:0] pad_pullup,
  // outside source
  input wire logic [21:0] ext_en,
  input wire logic [21:0] ext_val,
  // resolved levels
  output logic [21:0] pad_in
);
  logic [21:0] float_ff = 22'h155555;
  // floating pads toggle so stale levels never look valid
  always @(posedge clk_sys) float_ff <= ~float_ff;
  // block driver first, then outside source, pull-up, float
  always_comb begin
    for (int i = 0; i < 22; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup[i]) pad_in[i] = 1'b1;
      else pad_in[i] = float_ff[i];
    end
  end
endmodule : ioppc_pad_model
`default_nettype wire

// >>> tb/tb_ioppc_top.sv
// self-checking bench for the pad control block
`timescale 1ns/1ps
`default_nettype none
module tb_ioppc_top;
  import ioppc_pkg::*;
  logic CLK_SYS = 1'b0;
  logic NRST = 1'b0;
  logic REG_WR = 1'b0, D_SET = 1'b0, D_CLR = 1'b0, D_TEST = 1'b0, R_WRITE = 1'b0, R_READ = 1'b0;
  logic STOP_MODE = 1'b0, PERI_SCK_OUT = 1'b0, PERI_SCK_OE = 1'b0, PERI_SO = 1'b0, PERI_TOC = 1'b0;
  logic [9:0] REG_ADDR = 10'h000;
  logic [3:0] REG_WDATA = 4'h0, R_WDATA = 4'h0, R_RDATA;
  logic [2:0] D_BIT = 3'h0;
  logic [1:0] R_GROUP = 2'h0;
  logic [3:1] AN_SELECT;
  logic [21:0] PAD_IN, PAD_OUT, PAD_OE, PAD_PULLUP;
  logic [21:0] ext_en = 22'h0, ext_val = 22'h0;
  logic D_LEVEL, PERI_SCK_IN, PERI_SI, PERI_IRQ0_N, PERI_STOP_CLEAR_PIN_N;
  int errors = 0;
  int compares = 0;
  // 100 ns system clock
  always #50 CLK_SYS = ~CLK_SYS;
  ioppc_top ioppc_top_inst (.*);
  ioppc_pad_model ioppc_pad_model_inst (.clk_sys(CLK_SYS), .pad_out(PAD_OUT), .pad_oe(PAD_OE),
    .pad_pullup(PAD_PULLUP), .ext_en(ext_en), .ext_val(ext_val), .pad_in(PAD_IN));
  task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask : tick
  // one-cycle strobe on a register write or port instruction, then one idle cycle
  // so that a following strobe never re-raises in the same step
  task automatic strobe(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : strobe
  task automatic reg_wr(input logic [9:0] a, input logic [3:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    strobe(REG_WR);
  endtask : reg_wr
  task automatic results;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // hang guard
  initial begin
    #1000000;
    errors++;
    results();
  end
  // main sequence
  initial begin
    tick(3);
    NRST = 1'b1;
    chk("oe_reset", 22'h0, PAD_OE);
    reg_wr(ADDR_MISC, 4'h0);
    reg_wr(ADDR_MISC, 4'h8);
    tick(1);
    chk("pu_latches", PIN_CMOS & PIN_PRESENT, PAD_PULLUP);
    $display("test reset done");
    reg_wr(ADDR_DCD0, 4'hf);
    reg_wr(ADDR_DCD1, 4'hf);
    D_BIT = 3'h1;
    strobe(D_CLR);
    tick(1);
    chk("d_oe", 22'h3f, PAD_OE);
    chk("d_out", 22'h3d, PAD_OUT & 22'h3f);
    chk("d_pu", 22'h0, PAD_PULLUP & 22'h2);
    strobe(D_TEST);
    chk("d_lvl", 22'h0, D_LEVEL);
    D_BIT = 3'h2;
    strobe(D_TEST);
    chk("d_lvl", 22'h1, D_LEVEL);
    $display("test d port done");
    reg_wr(ADDR_DCR0 + 10'h1, 4'hf);
    tick(1);
    chk("od_float", 22'h0, PAD_OE & 22'h3c00);
    R_GROUP = 2'h1;
    strobe(R_WRITE);
    tick(1);
    chk("od_low", 22'h3c00, PAD_OE & 22'h3c00);
    chk("od_out", 22'h0, PAD_OUT & 22'h3c00);
    strobe(R_READ);
    chk("r_rd", 22'h0, R_RDATA);
    reg_wr(ADDR_DCR0 + 10'h1, 4'h0);
    reg_wr(10'h3ff, 4'hf);
    tick(1);
    chk("od_in", 22'h0, PAD_OE & 22'h3c00);
    ext_val = 22'h2800;
    ext_en = 22'h3c00;
    strobe(R_READ);
    chk("r_in", 22'ha, R_RDATA);
    ext_en = 22'h0;
    $display("test open drain done");
    PERI_SO = 1'b1;
    reg_wr(ADDR_PORT_MODE_REG_A, 4'h3);
    ext_en = 22'h80;
    tick(1);
    chk("so_cmos", 22'h100, PAD_OE & PAD_OUT & 22'h100);
    chk("si_in", 22'h0, PERI_SI);
    reg_wr(ADDR_MISC, 4'hc);
    tick(1);
    chk("so_od", 22'h0, PAD_OE & 22'h100);
    chk("so_pu", 22'h100, PAD_PULLUP & 22'h100);
    PERI_SO = 1'b0;
    reg_wr(ADDR_AMR, 4'he);
    tick(1);
    chk("so_low", 22'h100, PAD_OE & ~PAD_OUT & 22'h100);
    chk("an_sel", 22'h7, AN_SELECT);
    chk("an_pu", 22'h380000, PAD_PULLUP & 22'h380000);
    // clock, timer, interrupt and stop-clear pins taken by peripherals
    PERI_SCK_OUT = 1'b1;
    PERI_SCK_OE = 1'b0;
    PERI_TOC = 1'b1;
    reg_wr(ADDR_PORT_MODE_REG_A, 4'h7);
    reg_wr(ADDR_SMR, 4'h8);
    reg_wr(ADDR_PORT_MODE_REG_B, 4'h9);
    ext_en = 22'h51;
    tick(1);
    chk("toc_out", 22'h200, PAD_OE & PAD_OUT & 22'h200);
    chk("sck_float", 22'h0, PAD_OE & 22'h51);
    chk("sck_in", 22'h0, PERI_SCK_IN);
    chk("irq0_in", 22'h0, PERI_IRQ0_N);
    chk("stop_clear_pin_in", 22'h0, PERI_STOP_CLEAR_PIN_N);
    PERI_SCK_OE = 1'b1;
    tick(2);
    chk("sck_out", 22'h40, PAD_OE & PAD_OUT & 22'h40);
    ext_en = 22'h0;
    $display("test peripherals done");
    STOP_MODE = 1'b1;
    tick(3);
    chk("stop_oe", 22'h0, PAD_OE);
    chk("stop_pu", 22'h0, PAD_PULLUP);
    STOP_MODE = 1'b0;
    tick(2);
    chk("stop_an", 22'h0, AN_SELECT);
    chk("stop_misc", 22'h0, PAD_PULLUP);
    chk("stop_dir", 22'h0, PAD_OE);
    reg_wr(ADDR_MISC, 4'h8);
    tick(1);
    chk("stop_lat", PIN_CMOS & PIN_PRESENT, PAD_PULLUP);
    $display("test stop done");
    results();
  end
endmodule : tb_ioppc_top
`default_nettype wire
